// ==== include/clk_levels_if.sv ====
/*
 * Divided clock levels passed from the prescaler to the channels.
 * Assumes one producer and one consumer in the same clock domain.
 */
interface clk_levels_if;
	logic [3:0] lvl;
	modport src (output lvl);
	modport dst (input lvl);
endinterface

// ==== include/timer_pkg.sv ====
/*
 * Shared constants, field positions, reset values and types of the
 * three-channel 16-bit timer block.
 * Assumes a 32-bit classic Wishbone slave port with byte addresses.
 */
// Functional notes
// R1: Each channel has a 16-bit counter stepping on its selected clock edge, readable.
// R2: Wrap from all ones to zero sets the overflow flag in status.
// R3: A trigger zeroes the counter at the next active clock edge only.
// R4: Block mode register routes pins or other channels' line A to external clocks.
// R5: Clock select picks one of five internal or three external clocks.
// R6: Clock invert bit makes the counter use the opposite clock edge.
// R7: Burst setting lets the clock through only while the chosen input is high.
// R8: External clocks hold each level over one period, rate below clock/2.5.
// R9: Enable/disable commands gate the clock; start/stop ignored while disabled.
// R10: Load of B or compare C disables the clock when the matching bit is set.
// R11: Status shows a clock-enabled bit while the counting clock is enabled.
// R12: Every trigger starts the clock; load B or compare C may stop it.
// R13: Waveform bit picks mode; line A drives in waveform, B unless event.
// R14: Writing the software trigger bit triggers that channel.
// R15: Block sync bit triggers all three channels in the same cycle.
// R16: With the compare trigger bit set, counter equal to C triggers.
// R17: External trigger pulses must last longer than one clock period.
// R18: Waveform external event on B or external clocks triggers only when enabled.
// R19: Capture loads A and B on line A edges, each with its own edge field.
// R20: A loads only if unloaded since trigger or B loaded after A.
// R21: B loads only after A loaded since trigger or since B's last load.
// R22: Reloading a capture register before it is read sets the overrun flag.
// R23: Capture trigger source bit picks line A or B; edge field zero disables.
// R24: Internal clocks are clock divided by 2, 8, 32, 128 and the slow clock.
// R25: Capture registers are read-only in capture mode, writable in waveform mode.
// R26: Interrupt output is high while any unmasked status flag is set.
package timer_pkg;
	localparam int         NCH      = 3;
	localparam int         CMR_W    = 20;
	localparam logic [1:0] CH_BLOCK = 2'h3;
	localparam logic [5:0] OFF_CCR  = 6'h00;
	localparam logic [5:0] OFF_CMR  = 6'h04;
	localparam logic [5:0] OFF_CV   = 6'h10;
	localparam logic [5:0] OFF_RA   = 6'h14;
	localparam logic [5:0] OFF_RB   = 6'h18;
	localparam logic [5:0] OFF_RC   = 6'h1c;
	localparam logic [5:0] OFF_SR   = 6'h20;
	localparam logic [5:0] OFF_IER  = 6'h24;
	localparam logic [5:0] OFF_IDR  = 6'h28;
	localparam logic [5:0] OFF_IMR  = 6'h2c;
	localparam logic [5:0] OFF_BCR  = 6'h00;
	localparam logic [5:0] OFF_BMR  = 6'h04;
	localparam int         CM_CS    = 0;
	localparam int         CM_INV   = 3;
	localparam int         CM_BURST = 4;
	localparam int         CM_STOP  = 6;
	localparam int         CM_DIS   = 7;
	localparam int         CM_EEDGE = 8;
	localparam int         CM_ESRC  = 10;
	localparam int         CM_EEVT  = 10;
	localparam int         CM_ENTRG = 12;
	localparam int         CM_CTRG  = 14;
	localparam int         CM_WAVE  = 15;
	localparam int         CM_LDA   = 16;
	localparam int         CM_LDB   = 18;
	localparam int         CC_EN    = 0;
	localparam int         CC_DIS   = 1;
	localparam int         CC_SWT   = 2;
	localparam int         BCR_SYNC = 0;
	localparam int         SR_OVF   = 0;
	localparam int         SR_LOVR  = 1;
	localparam int         SR_CPC   = 4;
	localparam int         SR_LDA   = 5;
	localparam int         SR_LDB   = 6;
	localparam int         SR_ETRG  = 7;
	localparam int         SR_CLKST = 16;
	localparam logic [5:0] BMR_RST  = 6'h00;
	localparam int         PRE_W    = 7;
	localparam int         TAP [4]  = '{0, 2, 4, 6};

	typedef enum logic [1:0] {
		WAIT_A = 2'h1,
		WAIT_B = 2'h2
	} load_seq_t;

	typedef struct packed {
		logic [15:0]      cv;
		logic [15:0]      ra;
		logic [15:0]      rb;
		logic [15:0]      rc;
		logic [CMR_W-1:0] cmr;
		logic [7:0]       sr;
		logic [7:0]       imr;
		logic             en;
		logic             run;
		logic             pend;
		logic             ua;
		logic             ub;
		logic             a_out;
		logic             b_out;
		logic             aoe_n;
		logic             boe_n;
		logic             irq;
		load_seq_t        seq;
	} ch_state_t;

	localparam ch_state_t CH_RST = '{seq: WAIT_A, aoe_n: 1'b1, boe_n: 1'b1, default: '0};
endpackage

// ==== logic/edge_detect.sv ====
/*
 * Rising and falling edge pulses for a vector of synchronous levels.
 * Assumes inputs already belong to the clock domain.
 */
module edge_detect #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] lvl_i,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] prev;
	logic [W-1:0] next_prev;

	always_comb begin
		next_prev = lvl_i;
	end

	// Levels shorter than one period can be missed entirely
	always_ff @(posedge clk_i) begin
		if (rst_i)
			prev <= '0;
		else
			prev <= next_prev; // R8 R17
	end

	assign rise_o = lvl_i & ~prev;
	assign fall_o = ~lvl_i & prev;
endmodule

// ==== logic/prescaler.sv ====
/*
 * Free running divider making square-wave levels at clock/2/8/32/128.
 * Assumes the consumer detects edges of these levels itself.
 */
module prescaler (
	input  wire logic clk_i,
	input  wire logic rst_i,
	clk_levels_if.src lv
);
	import timer_pkg::*;

	logic [PRE_W-1:0] cnt;
	logic [PRE_W-1:0] next_cnt;

	always_comb begin
		next_cnt = cnt + PRE_W'(1);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt <= '0;
		else
			cnt <= next_cnt;
	end

	for (genvar i = 0; i < 4; i++) begin : g_tap
		assign lv.lvl[i] = cnt[TAP[i]]; // R24
	end
endmodule

// ==== logic/timer_block.sv ====
/*
 * Three-channel 16-bit timer with capture, clock control, triggers and
 * block level clock chaining, behind a classic Wishbone slave.
 * Assumes all pins are synchronous to clk_i; the slow clock arrives as
 * a level input sampled on clk_i.
 */
module timer_block (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [31:0]              wb_dat_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic                     wb_we_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     slow_clock_i,
	input  wire logic [2:0]               ext_clock_pin_i,
	input  wire logic [timer_pkg::NCH-1:0] line_a_i,
	output logic      [timer_pkg::NCH-1:0] line_a_o,
	output logic      [timer_pkg::NCH-1:0] line_a_oe_n_o,
	input  wire logic [timer_pkg::NCH-1:0] line_b_i,
	output logic      [timer_pkg::NCH-1:0] line_b_o,
	output logic      [timer_pkg::NCH-1:0] line_b_oe_n_o,
	output logic      [timer_pkg::NCH-1:0] irq_o
);
	import timer_pkg::*;

	logic             acc;
	logic             wr;
	logic             rd;
	logic             blk;
	logic [5:0]       off;
	logic [31:0]      wm;
	logic [31:0]      wdat;
	logic             sync_trig;
	logic [2:0]       xc;
	logic [NCH-1:0]   a_lvl;
	logic [3*NCH-1:0] lvl;
	logic [3*NCH-1:0] rise;
	logic [3*NCH-1:0] fall;
	ch_state_t        st [NCH];
	ch_state_t        next_st [NCH];
	ch_state_t        cur;
	logic             ack;
	logic             next_ack;
	logic [31:0]      dat;
	logic [31:0]      next_dat;
	logic [5:0]       bmr;
	logic [5:0]       next_bmr;

	clk_levels_if lv ();

	// Field code 1 rising, 2 falling, 3 both, 0 none
	function automatic logic edge_hit(
		input logic [1:0] sel,
		input logic       r,
		input logic       f
	);
		return (sel[0] & r) | (sel[1] & f);
	endfunction

	prescaler u_pre (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lv    (lv)
	);

	edge_detect #(
		.W (3 * NCH)
	) u_edge (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.lvl_i  (lvl),
		.rise_o (rise),
		.fall_o (fall)
	);

	// Bus decode
	assign acc = wb_cyc_i & wb_stb_i & ~ack;
	assign wr = acc & wb_we_i;
	assign rd = acc & ~wb_we_i;
	assign blk = wb_adr_i[7:6] == CH_BLOCK;
	assign off = wb_adr_i[5:0];
	assign wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat = wb_dat_i & wm;
	assign sync_trig = wr & blk & (off == OFF_BCR) & wdat[BCR_SYNC]; // R15

	// External clock routing; a channel may chain from its neighbours
	for (genvar j = 0; j < 3; j++) begin : g_xc
		localparam int P = (j + 1) % NCH;
		localparam int Q = (j + 2) % NCH;

		always_comb begin
			case (bmr[2*j+:2])
				2'h0: begin
					xc[j] = ext_clock_pin_i[j]; // R4
				end
				2'h2: begin
					xc[j] = a_lvl[P]; // R4
				end
				2'h3: begin
					xc[j] = a_lvl[Q]; // R4
				end
				default: begin
					xc[j] = 1'b0;
				end
			endcase
		end
	end

	for (genvar k = 0; k < NCH; k++) begin : g_ch
		localparam int E = 3 * k;

		logic [CMR_W-1:0] m;
		logic             wave;
		logic             hit;
		logic             wr_ch;
		logic             rd_ch;
		logic [7:0]       clk_srcs;
		logic [3:0]       burst_srcs;
		logic [3:0]       evt_srcs;
		logic             clk_lvl;
		logic             evt_lvl;
		logic             tick;
		logic [15:0]      inc;
		logic             ovf;
		logic             cpc;
		logic             ccr_wr;
		logic             ext;
		logic             trig;
		logic             la;
		logic             lb;
		logic             stop;
		logic             dis;

		assign m = st[k].cmr;
		assign wave = m[CM_WAVE]; // R13
		assign hit = ~blk & (wb_adr_i[7:6] == 2'(k));
		assign wr_ch = wr & hit;
		assign rd_ch = rd & hit;
		assign a_lvl[k] = wave ? st[k].a_out : line_a_i[k];

		assign clk_srcs = {xc, slow_clock_i, lv.lvl}; // R24
		assign burst_srcs = {xc, 1'b1};
		assign evt_srcs = {xc, line_b_i[k]};
		assign clk_lvl = (clk_srcs[m[CM_CS+:3]] ^ m[CM_INV]) // R5 R6
			& burst_srcs[m[CM_BURST+:2]]; // R7
		assign evt_lvl = wave ? evt_srcs[m[CM_EEVT+:2]] // R18
			: (m[CM_ESRC] ? line_a_i[k] : line_b_i[k]); // R23
		assign lvl[E+:3] = {evt_lvl, clk_lvl, a_lvl[k]};

		assign tick = rise[E+1] & st[k].en & st[k].run; // R1 R9
		assign inc = st[k].cv + 16'h0001;
		assign ovf = tick & ~st[k].pend & (st[k].cv == 16'hffff); // R2
		assign cpc = tick & ~st[k].pend & (inc == st[k].rc);
		assign ccr_wr = wr_ch & (off == OFF_CCR);

		assign ext = edge_hit(m[CM_EEDGE+:2], rise[E+2], fall[E+2]) // R23
			& (~wave | m[CM_ENTRG]); // R18
		assign trig = ext
			| sync_trig // R15
			| (ccr_wr & wdat[CC_SWT]) // R14
			| (cpc & m[CM_CTRG]); // R16

		// Both fields on one edge: A takes it when A is due
		assign la = ~wave & (st[k].seq == WAIT_A) // R20
			& edge_hit(m[CM_LDA+:2], rise[E], fall[E]); // R19
		assign lb = ~wave & (st[k].seq == WAIT_B) // R21
			& edge_hit(m[CM_LDB+:2], rise[E], fall[E]); // R19

		assign stop = (lb | (wave & cpc)) & m[CM_STOP]; // R12
		assign dis = ((lb | (wave & cpc)) & m[CM_DIS]) // R10
			| (ccr_wr & wdat[CC_DIS]); // R9

		always_comb begin
			next_st[k] = st[k];

			// Counter; a pending trigger lands on the next active edge
			if (tick) begin
				next_st[k].cv = st[k].pend ? 16'h0000 : inc; // R1 R3
				next_st[k].pend = 1'b0;
			end
			if (trig & st[k].en)
				next_st[k].pend = 1'b1; // R3

			// Disable beats enable when both are written together
			if (dis)
				next_st[k].en = 1'b0; // R9 R10
			else if (ccr_wr & wdat[CC_EN])
				next_st[k].en = 1'b1; // R9

			// Stop beats a simultaneous trigger
			if (st[k].en) begin
				if (stop)
					next_st[k].run = 1'b0; // R12
				else if (trig)
					next_st[k].run = 1'b1; // R12
			end

			case (st[k].seq)
				WAIT_A: begin
					if (la)
						next_st[k].seq = WAIT_B; // R20
				end
				WAIT_B: begin
					if (lb)
						next_st[k].seq = WAIT_A; // R21
				end
				default: begin
					next_st[k].seq = WAIT_A;
				end
			endcase
			if (trig)
				next_st[k].seq = WAIT_A; // R20 R21

			if (la)
				next_st[k].ra = st[k].cv; // R19
			else if (wr_ch & wave & (off == OFF_RA))
				next_st[k].ra = (st[k].ra & ~wm[15:0]) | wdat[15:0]; // R25
			if (lb)
				next_st[k].rb = st[k].cv; // R19
			else if (wr_ch & wave & (off == OFF_RB))
				next_st[k].rb = (st[k].rb & ~wm[15:0]) | wdat[15:0]; // R25
			if (wr_ch & (off == OFF_RC))
				next_st[k].rc = (st[k].rc & ~wm[15:0]) | wdat[15:0];
			if (wr_ch & (off == OFF_CMR))
				next_st[k].cmr = (m & ~wm[CMR_W-1:0]) | wdat[CMR_W-1:0];

			// Unread markers; a load in the read cycle wins
			if (rd_ch & (off == OFF_RA))
				next_st[k].ua = 1'b0;
			if (la)
				next_st[k].ua = 1'b1; // R22
			if (rd_ch & (off == OFF_RB))
				next_st[k].ub = 1'b0;
			if (lb)
				next_st[k].ub = 1'b1; // R22

			// Status clears on read; events in that cycle still land
			if (rd_ch & (off == OFF_SR))
				next_st[k].sr = 8'h00;
			next_st[k].sr[SR_OVF] = next_st[k].sr[SR_OVF] | ovf; // R2
			next_st[k].sr[SR_LOVR] = next_st[k].sr[SR_LOVR]
				| (la & st[k].ua) | (lb & st[k].ub); // R22
			next_st[k].sr[SR_CPC] = next_st[k].sr[SR_CPC] | cpc;
			next_st[k].sr[SR_LDA] = next_st[k].sr[SR_LDA] | la;
			next_st[k].sr[SR_LDB] = next_st[k].sr[SR_LDB] | lb;
			next_st[k].sr[SR_ETRG] = next_st[k].sr[SR_ETRG] | ext;

			if (wr_ch & (off == OFF_IER))
				next_st[k].imr = st[k].imr | wdat[7:0];
			if (wr_ch & (off == OFF_IDR))
				next_st[k].imr = st[k].imr & ~wdat[7:0];
			next_st[k].irq = |(next_st[k].sr & next_st[k].imr); // R26

			// Minimal waveform outputs: toggle on compare C
			if (wave & cpc) begin
				next_st[k].a_out = ~st[k].a_out;
				next_st[k].b_out = ~st[k].b_out;
			end
			next_st[k].aoe_n = ~next_st[k].cmr[CM_WAVE]; // R13
			next_st[k].boe_n = ~(next_st[k].cmr[CM_WAVE] // R13
				& (next_st[k].cmr[CM_EEVT+:2] != 2'h0));
		end

		always_ff @(posedge clk_i) begin
			if (rst_i)
				st[k] <= CH_RST;
			else
				st[k] <= next_st[k];
		end

		assign line_a_o[k] = st[k].a_out;
		assign line_a_oe_n_o[k] = st[k].aoe_n;
		assign line_b_o[k] = st[k].b_out;
		assign line_b_oe_n_o[k] = st[k].boe_n;
		assign irq_o[k] = st[k].irq;
	end

	// Register read mux and block registers
	always_comb begin
		case (wb_adr_i[7:6])
			2'h0: begin
				cur = st[0];
			end
			2'h1: begin
				cur = st[1];
			end
			default: begin
				cur = st[2];
			end
		endcase
	end

	always_comb begin
		next_ack = acc;
		next_bmr = bmr;
		next_dat = 32'h0000_0000;
		if (wr & blk & (off == OFF_BMR))
			next_bmr = (bmr & ~wm[5:0]) | wdat[5:0]; // R4
		// Unmapped or write-only offsets still ack, reading zero
		if (rd & blk) begin
			if (off == OFF_BMR)
				next_dat = 32'(bmr);
		end else if (rd) begin
			case (off)
				OFF_CMR: begin
					next_dat = 32'(cur.cmr);
				end
				OFF_CV: begin
					next_dat = 32'(cur.cv); // R1
				end
				OFF_RA: begin
					next_dat = 32'(cur.ra);
				end
				OFF_RB: begin
					next_dat = 32'(cur.rb);
				end
				OFF_RC: begin
					next_dat = 32'(cur.rc);
				end
				OFF_SR: begin
					next_dat = 32'(cur.sr) | (32'(cur.en) << SR_CLKST); // R11
				end
				OFF_IMR: begin
					next_dat = 32'(cur.imr);
				end
				default: begin
					next_dat = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			dat <= 32'h0000_0000;
			bmr <= BMR_RST;
		end else begin
			ack <= next_ack;
			dat <= next_dat;
			bmr <= next_bmr;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = dat;
endmodule

// ==== test/ext_pins_model.sv ====
/*
 * Far side of the timer: external clock pins and line inputs.
 * Assumes the caller waits for each task; line B wanders freely.
 */
module ext_pins_model (
	input wire logic  clk_i,
	output logic [2:0] pin_o,
	output logic [2:0] line_a_o,
	output logic [2:0] line_b_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 32'h0000_6295;
	initial begin
		pin_o = 3'h0;
		line_a_o = 3'h0;
		line_b_o = 3'h0;
	end
	// Noise so a trigger path left open would show
	always @(posedge clk_i)
		line_b_o <= 3'($random(seed));
	task automatic clocks(input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge clk_i);
			pin_o[0] <= 1'b1;
			repeat (half) @(posedge clk_i);
			pin_o[0] <= 1'b0;
		end
	endtask
	task automatic pulse(input int ch, input int lead, input int hi);
		repeat (lead) @(posedge clk_i);
		line_a_o[ch] <= 1'b1;
		repeat (hi) @(posedge clk_i);
		line_a_o[ch] <= 1'b0;
	endtask
	task automatic level(input int p, input logic v);
		@(posedge clk_i);
		pin_o[p] <= v;
	endtask
endmodule

// ==== test/timer_block_bench.sv ====
/*
 * Self-checking bench for the timer block: reset values, clocking,
 * capture, compare trigger and block sync over Wishbone.
 * Assumes the pin model answers on the same clock.
 */
module timer_block_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		string       n;
		logic [31:0] m;
		logic [31:0] e;
	} note_t;
	localparam logic [5:0] OFFS [9] = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h14,
		6'h18, 6'h1c, 6'h20, 6'h2c};
	logic        clk;
	logic        rst = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic        we = 1'b0;
	logic        cyc = 1'b0;
	logic [31:0] rdat;
	logic        ack;
	logic [2:0]  pin, la, lb, irq, ao, bo, aoe, boe;
	int          err_total;
	int          samples_checked;
	int          seed;
	note_t       q[$];
	note_t       cur;
	timer_block i_dut (
		.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
		.wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack),
		.slow_clock_i(1'b0), .ext_clock_pin_i(pin), .line_a_i(la), .line_a_o(ao),
		.line_a_oe_n_o(aoe), .line_b_i(lb), .line_b_o(bo), .line_b_oe_n_o(boe), .irq_o(irq)
	);
	ext_pins_model i_pins (.clk_i(clk), .pin_o(pin), .line_a_o(la), .line_b_o(lb));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		adr <= a;
		dat <= d;
		we <= w;
		cyc <= 1'b1;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
	endtask
	task automatic rd(string n, logic [7:0] a, logic [31:0] m, logic [31:0] e);
		q.push_back('{n, m, e});
		bus(a, 32'h0000_0000, 1'b0);
	endtask
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
			cur = q.pop_front();
			check(cur.n, rdat & cur.m, cur.e);
		end
	end
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Whole run is near 1300 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	initial begin
		int half;
		int rc;
		seed = 32'h0000_6295;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int c = 0; c < 4; c++)
			foreach (OFFS[i])
				rd("reset", {c[1:0], OFFS[i]}, 32'hffff_ffff, 32'h0000_0000);
		bus(8'h14, 32'h0000_1234, 1'b1);
		rd("ra0", 8'h14, 32'hffff_ffff, 32'h0000_0000);
		// External clock on pin 0; enable apart from trigger
		half = 2 + $unsigned($random(seed)) % 3;
		bus(8'h04, 32'h0000_0005, 1'b1);
		bus(8'h00, 32'h0000_0001, 1'b1);
		bus(8'h00, 32'h0000_0004, 1'b1);
		i_pins.clocks(10, half);
		repeat (4) @(posedge clk);
		rd("cv0", 8'h10, 32'hffff_ffff, 32'h0000_0009);
		rd("clkst", 8'h20, 32'h0001_0000, 32'h0001_0000);
		bus(8'h00, 32'h0000_0002, 1'b1);
		bus(8'h00, 32'h0000_0004, 1'b1);
		i_pins.clocks(4, half);
		rd("cv0", 8'h10, 32'hffff_ffff, 32'h0000_0009);
		rd("clkst", 8'h20, 32'h0001_0000, 32'h0000_0000);
		// Inverted pin clock, gated by pin 1 as burst input
		bus(8'h04, 32'h0000_002d, 1'b1);
		bus(8'h00, 32'h0000_0001, 1'b1);
		bus(8'h00, 32'h0000_0004, 1'b1);
		i_pins.clocks(3, half);
		rd("cv0", 8'h10, 32'hffff_ffff, 32'h0000_0009);
		// Clock parked high first so opening the gate makes no edge
		i_pins.level(0, 1'b1);
		i_pins.level(1, 1'b1);
		i_pins.clocks(5, half);
		repeat (4) @(posedge clk);
		rd("cv0", 8'h10, 32'hffff_ffff, 32'h0000_0004);
		// Capture: A on rise, B on fall, stop on B
		bus(8'h44, 32'h0009_0040, 1'b1);
		bus(8'h64, 32'h0000_0020, 1'b1);
		bus(8'h40, 32'h0000_0001, 1'b1);
		bus(8'h40, 32'h0000_0004, 1'b1);
		i_pins.pulse(1, 72, 64);
		repeat (6) @(posedge clk);
		check("irq1", {31'h0000_0000, irq[1]}, 32'h0000_0001);
		rd("sr1", 8'h60, 32'h0001_00ff, 32'h0001_0060);
		rd("ra1", 8'h54, 32'hffff_ffe0, 32'h0000_0020);
		rd("rb1", 8'h58, 32'hffff_ffe0, 32'h0000_0040);
		repeat (200) @(posedge clk);
		rd("cv1", 8'h50, 32'hffff_ffe0, 32'h0000_0040);
		check("irq1", {31'h0000_0000, irq[1]}, 32'h0000_0000);
		i_pins.pulse(1, 8, 8);
		repeat (6) @(posedge clk);
		rd("sr1", 8'h60, 32'h0000_00e3, 32'h0000_0060);
		i_pins.pulse(1, 8, 8);
		repeat (6) @(posedge clk);
		rd("sr1", 8'h60, 32'h0000_00e3, 32'h0000_0062);
		// Compare trigger keeps the count at or below a random limit
		rc = 1 + $unsigned($random(seed)) % 15;
		bus(8'h84, 32'h0000_4000, 1'b1);
		bus(8'h9c, 32'(rc), 1'b1);
		bus(8'h80, 32'h0000_0001, 1'b1);
		bus(8'h80, 32'h0000_0004, 1'b1);
		repeat (8) begin
			repeat (5 + $unsigned($random(seed)) % 20) @(posedge clk);
			rd("cv2", 8'h90, 32'hffff_fff0, 32'h0000_0000);
		end
		rd("sr2", 8'ha0, 32'h0000_0010, 32'h0000_0010);
		// Waveform mode, event on an external clock, disable on compare C
		bus(8'h84, 32'h0000_8880, 1'b1);
		bus(8'h94, 32'h0000_1234, 1'b1);
		rd("ra2", 8'h94, 32'h0000_ffff, 32'h0000_1234);
		repeat (40) @(posedge clk);
		rd("cv2", 8'h90, 32'h0000_ffff, 32'(rc));
		rd("sr2", 8'ha0, 32'h0001_0010, 32'h0000_0010);
		check("wave2", {28'h000_0000, ao[2], bo[2], aoe[2], boe[2]}, 32'h0000_000c);
		// Sync restarts the channel stopped by its B load
		bus(8'h04, 32'h0000_0000, 1'b1);
		bus(8'h00, 32'h0000_0001, 1'b1);
		bus(8'hc0, 32'h0000_0001, 1'b1);
		repeat (300) @(posedge clk);
		rd("cv0", 8'h10, 32'hffff_ff80, 32'h0000_0080);
		rd("cv1", 8'h50, 32'hffff_ff80, 32'h0000_0080);
		rd("cv2", 8'h90, 32'h0000_ffff, 32'(rc));
		// Channel 0 chained to line A of channel 1, which also triggers 1
		bus(8'hc4, 32'h0000_0002, 1'b1);
		rd("bmr", 8'hc4, 32'hffff_ffff, 32'h0000_0002);
		bus(8'h04, 32'h0000_0005, 1'b1);
		bus(8'h00, 32'h0000_0004, 1'b1);
		bus(8'h44, 32'h0000_0500, 1'b1);
		i_pins.pulse(1, 4, 4);
		i_pins.pulse(1, 4, 4);
		repeat (4) @(posedge clk);
		rd("cv0", 8'h10, 32'hffff_ffff, 32'h0000_0001);
		rd("cv1", 8'h50, 32'hffff_ffc0, 32'h0000_0000);
		rd("sr1", 8'h60, 32'h0000_0080, 32'h0000_0080);
		print_verdict();
	end
endmodule

// ==== test/timer_block_props.sv ====
/*
 * Checker for the timer block top: bus handshake, reset state,
 * pin direction in capture mode and interrupt masking.
 * Assumes every mode and mask change arrives over the bus.
 */
module timer_block_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [2:0]  line_a_oe_n_o,
	input wire logic [2:0]  line_b_oe_n_o,
	input wire logic [2:0]  irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0]      wave, next_wave, old_wave, mask_on, old_mask;
	logic [2:0][7:0] imr, next_imr;
	logic            wr_take;
	// Shadow of mode and mask, one cycle of slack for registered pins
	always_comb begin
		wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
		next_wave = wave;
		next_imr = imr;
		for (int c = 0; c < 3; c++) begin
			mask_on[c] = |imr[c];
			if (wr_take && wb_adr_i[7:6] == c[1:0]) begin
				if (wb_adr_i[5:0] == 6'h04)
					next_wave[c] = wb_dat_i[15];
				if (wb_adr_i[5:0] == 6'h24)
					next_imr[c] = imr[c] | wb_dat_i[7:0];
				if (wb_adr_i[5:0] == 6'h28)
					next_imr[c] = imr[c] & ~wb_dat_i[7:0];
			end
		end
	end
	always_ff @(posedge clk_i) begin
		wave <= rst_i ? 3'h0 : next_wave;
		imr <= rst_i ? '0 : next_imr;
		old_wave <= rst_i ? 3'h0 : wave;
		old_mask <= rst_i ? 3'h0 : mask_on;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack_once;
		s_take |=> s_answer;
	endproperty
	property p_no_ack;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	property p_hole_zero;
		s_take ##0 (!wb_we_i && wb_adr_i[5:0] inside {6'h08, 6'h0c})
			|=> wb_ack_o && wb_dat_o == 32'h0000_0000;
	endproperty
	property p_wo_zero;
		s_take ##0 (!wb_we_i && wb_adr_i[5:0] inside {6'h00, 6'h24, 6'h28})
			|=> wb_dat_o == 32'h0000_0000;
	endproperty
	property p_reset_quiet;
		$fell(rst_i) |-> !wb_ack_o && irq_o == 3'h0 && &line_a_oe_n_o && &line_b_oe_n_o;
	endproperty
	property p_capture_in;
		((line_a_oe_n_o & line_b_oe_n_o) | wave | old_wave) == 3'h7;
	endproperty
	property p_irq_masked;
		(irq_o & ~(mask_on | old_mask)) == 3'h0;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack not one pulse");
	a_no_ack: assert property (p_no_ack) else $error("ack without request");
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	a_hole_zero: assert property (p_hole_zero) else $error("hole not zero");
	a_wo_zero: assert property (p_wo_zero) else $error("write-only not zero");
	a_reset_quiet: assert property (p_reset_quiet) else $error("reset state");
	a_capture_in: assert property (p_capture_in) else $error("line driven");
	a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
endmodule

bind timer_block timer_block_props i_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_a_oe_n_o(line_a_oe_n_o),
	.line_b_oe_n_o(line_b_oe_n_o), .irq_o(irq_o)
);
